/* hw/adcs_pkg.sv */
package adcs_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PINCFG = 8'h04;
  localparam logic [7:0] OFF_TIMING = 8'h08;
  localparam logic [7:0] OFF_RESH   = 8'h0c;
  localparam logic [7:0] OFF_RESL   = 8'h10;
  localparam logic [7:0] OFF_CMP    = 8'h14;
  localparam logic [7:0] OFF_STAT   = 8'h18;
  localparam logic [7:0] OFF_PORT   = 8'h1c;
  localparam logic [7:0] OFF_NONE   = 8'hff;

  // field positions
  localparam int CTRL_ON   = 0;
  localparam int CTRL_GO   = 1;
  localparam int CTRL_CHAN = 2;
  localparam int TIM_CS    = 0;
  localparam int TIM_ACQ   = 3;
  localparam int TIM_JUST  = 7;
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;

  // reset values
  localparam logic [3:0] PCFG_RST    = 4'h0;
  localparam logic [3:0] PCFG_PB_DIG = 4'h7;
  localparam logic [2:0] ACQ_RST     = 3'h0;
  localparam logic [2:0] CS_RST      = 3'h0;
  localparam logic [3:0] CMP_RST     = 4'h0;
  localparam logic [3:0] CHAN_RST    = 4'h0;
  localparam logic [7:0] RES_RST     = 8'h00;

  localparam logic [3:0] CMP_TRIG_MODE = 4'hb;

  // timing
  localparam int OSC_MHZ = 20;
  localparam int TCY_NS  = 200;
  localparam int TCY_CYC = (TCY_NS * OSC_MHZ + 999) / 1000;
  localparam logic [4:0] CONV_TADS = 5'h0b;
  localparam logic [4:0] WAIT_TADS = 5'h02;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_ACQ   = 3'b010,
    ST_CONV  = 3'b011,
    ST_WAIT  = 3'b100
  } adcs_state_t;

  typedef struct packed {
    logic       sample_en;
    logic       bit_strobe;
    logic       conv_start;
    logic [3:0] channel;
  } adcs_ana_t;

endpackage

/* hw/adcs_tad_gen.sv */
module adcs_tad_gen #(
  parameter int DIV_W = 6
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       sleep_mode,
  input  wire logic       rc_clk,
  input  wire logic [2:0] sel,
  output logic            tick
);

  if (DIV_W < 6) begin : g_chk
    $error("DIV_W too small for 64 oscillator periods");
  end

  logic [DIV_W-1:0] div_reg;
  logic             rc_s1_reg;
  logic             rc_s2_reg;
  logic             rc_s3_reg;

  // terminal count, one less than the period in oscillator cycles
  function automatic logic [DIV_W-1:0] div_term(input logic [2:0] s);
    case (s)
      3'b000:  div_term = DIV_W'(1);
      3'b100:  div_term = DIV_W'(3);
      3'b001:  div_term = DIV_W'(7);
      3'b101:  div_term = DIV_W'(15);
      3'b010:  div_term = DIV_W'(31);
      3'b110:  div_term = DIV_W'(63);
      default: div_term = DIV_W'(0);
    endcase
  endfunction

  wire use_rc   = (sel[1:0] == 2'b11);
  wire osc_run  = run & ~sleep_mode & ~use_rc;
  wire div_end  = (div_reg == div_term(sel));
  wire rc_edge  = rc_s2_reg & ~rc_s3_reg;
  wire osc_tick = osc_run & div_end;
  wire rc_tick  = run & use_rc & rc_edge;

  assign tick = osc_tick | rc_tick;

  // oscillator stops in sleep, so the divider clears there
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
    end else if (ce) begin
      if (!osc_run || div_end) begin
        div_reg <= '0;
      end else begin
        div_reg <= div_reg + DIV_W'(1);
      end
    end
  end

  // rc clock is foreign: two flops before the edge detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else if (ce) begin
      rc_s1_reg <= rc_clk;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  property p_div2;
    @(posedge hclk) disable iff (!hresetn || !ce)
      (osc_tick && sel == 3'b000) ##1 (osc_run && $stable(sel))
      |-> !tick ##1 (tick || !osc_run);
  endproperty
  a_div2: assert property (p_div2) else $error("div2 period wrong");

endmodule // adcs_tad_gen

/* hw/adcs_sequencer.sv */
// Functional notes
// - conversion takes eleven bit periods
// - bit period from three-bit clock select
// - acquisition zero delays start one instruction
// - conversion continues through idle mode
// - output-driven pin still converted
// - analog pins read zero on port
// - fuse sets port b reset configuration
// - clearing go aborts, result kept
// - two bit periods wait, then sample
// - acquisition 010 gives four periods first
// - trigger sets go and clears timer
// - trigger ignored while off, timer cleared
// - finish loads result, clears go, flags
// - acquisition field sets automatic acquisition
// - no acquisition versus conversion indication
// - justify bit places result right or left
//
// Our own choices: the register addresses and register access over AHB-Lite.
module adcs_sequencer #(
  parameter int NCH = 13
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                rc_clk,
  input  wire logic                sleep_mode,
  input  wire logic                special_event,
  input  wire logic                portb_analog_at_reset,
  input  wire logic [NCH-1:0]      pin_in,
  input  wire logic [9:0]          sar_data,
  output adcs_pkg::adcs_ana_t      ana,
  output logic                     conv_done,
  output logic                     timer_reset
);

  if (NCH < 1 || NCH > 16) begin : g_chk
    $error("NCH must be 1 to 16");
  end

  adcs_pkg::adcs_state_t state_reg;
  adcs_pkg::adcs_state_t state_next;
  logic [4:0]     cnt_reg;
  logic [4:0]     cnt_next;
  logic [4:0]     ph_ticks_reg;
  logic           on_reg;
  logic           go_reg;
  logic           done_reg;
  logic           just_reg;
  logic           init_reg;
  logic           tmr_rst_reg;
  logic           abort_q_reg;
  logic [3:0]     chan_reg;
  logic [3:0]     pcfg_reg;
  logic [3:0]     mode_reg;
  logic [2:0]     acq_reg;
  logic [2:0]     cs_reg;
  logic [7:0]     resh_reg;
  logic [7:0]     resl_reg;
  logic [31:0]    hrdata_reg;
  logic           dp_valid_reg;
  logic           dp_write_reg;
  logic           rd_done_reg;
  logic [7:0]     dp_addr_reg;
  logic [NCH-1:0] pin_s1_reg;
  logic [NCH-1:0] pin_s2_reg;
  logic           tick;

  function automatic logic [4:0] acq_tads(input logic [2:0] a);
    case (a)
      3'b111:  acq_tads = 5'h14;
      3'b110:  acq_tads = 5'h10;
      3'b101:  acq_tads = 5'h0c;
      3'b100:  acq_tads = 5'h08;
      3'b011:  acq_tads = 5'h06;
      3'b010:  acq_tads = 5'h04;
      3'b001:  acq_tads = 5'h02;
      default: acq_tads = 5'h00;
    endcase
  endfunction

  function automatic logic [15:0] amask(input logic [3:0] p);
    for (int i = 0; i < 16; i++) begin
      amask[i] = (5'(i) + {1'b0, p}) < 5'h0f;
    end
  endfunction

  function automatic logic [15:0] fmt(input logic [9:0] d,
                                      input logic       right);
    fmt = right ? {6'h00, d} : {d, 6'h00};
  endfunction

  // bus decode
  wire accept   = hsel & htrans[1] & hready;
  wire in_range = (haddr[31:8] == 24'h000000) & (hsize == 3'b010);
  wire rd_pend  = dp_valid_reg & ~dp_write_reg & ~rd_done_reg;
  wire wr       = dp_valid_reg & dp_write_reg & ce;
  wire wr_ctrl  = wr & (dp_addr_reg == adcs_pkg::OFF_CTRL);
  wire wr_pcfg  = wr & (dp_addr_reg == adcs_pkg::OFF_PINCFG);
  wire wr_tim   = wr & (dp_addr_reg == adcs_pkg::OFF_TIMING);
  wire wr_resh  = wr & (dp_addr_reg == adcs_pkg::OFF_RESH);
  wire wr_resl  = wr & (dp_addr_reg == adcs_pkg::OFF_RESL);
  wire wr_cmp   = wr & (dp_addr_reg == adcs_pkg::OFF_CMP);
  wire wr_stat  = wr & (dp_addr_reg == adcs_pkg::OFF_STAT);

  // sequencing terms
  wire trig     = special_event & (mode_reg == adcs_pkg::CMP_TRIG_MODE);
  wire trig_go  = trig & on_reg;
  wire busy     = (state_reg == adcs_pkg::ST_DELAY) |
                  (state_reg == adcs_pkg::ST_ACQ) |
                  (state_reg == adcs_pkg::ST_CONV);
  wire start    = (state_reg == adcs_pkg::ST_IDLE) & go_reg & on_reg;
  wire finish   = (state_reg == adcs_pkg::ST_CONV) & tick &
                  (cnt_reg == adcs_pkg::CONV_TADS - 5'h01);
  // set from software or trigger wins over the hardware clear
  wire go_next  = trig_go ? 1'b1 :
                  wr_ctrl ? (hwdata[adcs_pkg::CTRL_GO] &
                             hwdata[adcs_pkg::CTRL_ON]) :
                  (finish | ~on_reg) ? 1'b0 : go_reg;
  wire abort    = busy & ~go_next & ~finish;
  // one stopped cycle after an abort restarts the divider: full wait periods
  wire tad_run  = on_reg & ~abort_q_reg & ((state_reg == adcs_pkg::ST_ACQ) |
                  (state_reg == adcs_pkg::ST_CONV) |
                  (state_reg == adcs_pkg::ST_WAIT));

  wire [15:0]    amask_w = amask(pcfg_reg);
  wire [NCH-1:0] port_rd = pin_s2_reg & ~amask_w[NCH-1:0];
  wire [15:0]    res_new = fmt(sar_data, just_reg);

  wire [31:0] rd_mux =
    (dp_addr_reg == adcs_pkg::OFF_CTRL)   ?
      {26'h0, chan_reg, go_reg, on_reg} :
    (dp_addr_reg == adcs_pkg::OFF_PINCFG) ? {28'h0, pcfg_reg} :
    (dp_addr_reg == adcs_pkg::OFF_TIMING) ?
      {24'h0, just_reg, 1'b0, acq_reg, cs_reg} :
    (dp_addr_reg == adcs_pkg::OFF_RESH)   ? {24'h0, resh_reg} :
    (dp_addr_reg == adcs_pkg::OFF_RESL)   ? {24'h0, resl_reg} :
    (dp_addr_reg == adcs_pkg::OFF_CMP)    ? {28'h0, mode_reg} :
    (dp_addr_reg == adcs_pkg::OFF_STAT)   ?
      {30'h0, ~(state_reg == adcs_pkg::ST_IDLE), done_reg} :
    (dp_addr_reg == adcs_pkg::OFF_PORT)   ?
      {{(32 - NCH){1'b0}}, port_rd} : 32'h00000000;

  // reads take one wait state so the answer comes from a flop
  assign hreadyout = ce & ~rd_pend;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  assign conv_done   = done_reg;
  assign timer_reset = tmr_rst_reg;

  // channel goes out regardless of pin direction
  assign ana.channel    = chan_reg;
  assign ana.sample_en  = on_reg & ~(state_reg == adcs_pkg::ST_CONV) &
                          ~(state_reg == adcs_pkg::ST_WAIT);
  assign ana.bit_strobe = (state_reg == adcs_pkg::ST_CONV) & tick;
  assign ana.conv_start = (state_next == adcs_pkg::ST_CONV) &
                          (state_reg != adcs_pkg::ST_CONV);

  adcs_tad_gen #(
    .DIV_W (6)
  ) u_tad (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .run        (tad_run),
    .sleep_mode (sleep_mode),
    .rc_clk     (rc_clk),
    .sel        (cs_reg),
    .tick       (tick)
  );

  // no idle input: the sequencer never pauses for idle mode
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      adcs_pkg::ST_IDLE: begin
        if (start) begin
          cnt_next   = 5'h00;
          state_next = (acq_reg == 3'b000) ? adcs_pkg::ST_DELAY :
                                             adcs_pkg::ST_ACQ;
        end
      end
      adcs_pkg::ST_DELAY: begin
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == 5'(adcs_pkg::TCY_CYC - 1)) begin
          cnt_next   = 5'h00;
          state_next = adcs_pkg::ST_CONV;
        end
      end
      adcs_pkg::ST_ACQ: begin
        if (tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == acq_tads(acq_reg) - 5'h01) begin
            cnt_next   = 5'h00;
            state_next = adcs_pkg::ST_CONV;
          end
        end
      end
      adcs_pkg::ST_CONV: begin
        if (tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (finish) begin
            cnt_next   = 5'h00;
            state_next = adcs_pkg::ST_WAIT;
          end
        end
      end
      adcs_pkg::ST_WAIT: begin
        if (tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == adcs_pkg::WAIT_TADS - 5'h01) begin
            cnt_next   = 5'h00;
            state_next = adcs_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        cnt_next   = 5'h00;
        state_next = adcs_pkg::ST_IDLE;
      end
    endcase
    if (abort) begin
      cnt_next   = 5'h00;
      state_next = adcs_pkg::ST_WAIT;
    end
    if (!on_reg) begin
      cnt_next   = 5'h00;
      state_next = adcs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg   <= adcs_pkg::ST_IDLE;
      cnt_reg     <= 5'h00;
      abort_q_reg <= 1'b0;
    end else if (ce) begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      abort_q_reg <= abort;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= adcs_pkg::OFF_NONE;
      rd_done_reg  <= 1'b0;
      hrdata_reg   <= 32'h00000000;
    end else if (ce) begin
      if (hready) begin
        dp_valid_reg <= accept;
        dp_write_reg <= hwrite;
        dp_addr_reg  <= in_range ? haddr[7:0] : adcs_pkg::OFF_NONE;
        rd_done_reg  <= 1'b0;
      end else if (rd_pend) begin
        rd_done_reg  <= 1'b1;
        hrdata_reg   <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_reg   <= 1'b0;
      go_reg   <= 1'b0;
      chan_reg <= adcs_pkg::CHAN_RST;
      just_reg <= 1'b0;
      acq_reg  <= adcs_pkg::ACQ_RST;
      cs_reg   <= adcs_pkg::CS_RST;
      mode_reg <= adcs_pkg::CMP_RST;
    end else if (ce) begin
      go_reg <= go_next;
      if (wr_ctrl) begin
        on_reg   <= hwdata[adcs_pkg::CTRL_ON];
        chan_reg <= hwdata[adcs_pkg::CTRL_CHAN +: 4];
      end
      if (wr_tim) begin
        just_reg <= hwdata[adcs_pkg::TIM_JUST];
        acq_reg  <= hwdata[adcs_pkg::TIM_ACQ +: 3];
        cs_reg   <= hwdata[adcs_pkg::TIM_CS +: 3];
      end
      if (wr_cmp) begin
        mode_reg <= hwdata[3:0];
      end
    end
  end

  // done: set wins over the write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_reg    <= 1'b0;
      tmr_rst_reg <= 1'b0;
    end else if (ce) begin
      tmr_rst_reg <= trig;
      if (finish) begin
        done_reg <= 1'b1;
      end else if (wr_stat && hwdata[adcs_pkg::STAT_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resh_reg <= adcs_pkg::RES_RST;
      resl_reg <= adcs_pkg::RES_RST;
    end else if (ce) begin
      if (finish) begin
        {resh_reg, resl_reg} <= res_new;
      end else begin
        if (wr_resh) resh_reg <= hwdata[7:0];
        if (wr_resl) resl_reg <= hwdata[7:0];
      end
    end
  end

  // fuse is caught once, on the first enabled edge after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_reg <= 1'b0;
      pcfg_reg <= adcs_pkg::PCFG_RST;
    end else if (ce) begin
      init_reg <= 1'b1;
      if (!init_reg) begin
        pcfg_reg <= portb_analog_at_reset ? adcs_pkg::PCFG_RST :
                                            adcs_pkg::PCFG_PB_DIG;
      end else if (wr_pcfg) begin
        pcfg_reg <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else if (ce) begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // helper: bit periods seen in the current phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ticks_reg <= 5'h00;
    end else if (ce) begin
      if (state_next != state_reg) ph_ticks_reg <= 5'h00;
      else if (tick) ph_ticks_reg <= ph_ticks_reg + 5'h01;
    end
  end

  sequence s_dly_go;
    start && acq_reg == 3'b000 ##1 (go_next && on_reg)[*4];
  endsequence

  property p_delay;
    @(posedge hclk) disable iff (!hresetn || !ce)
      s_dly_go |=> state_reg == adcs_pkg::ST_CONV;
  endproperty
  a_delay: assert property (p_delay) else $error("delay wrong");

  property p_conv_len;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == adcs_pkg::ST_CONV &&
       state_next == adcs_pkg::ST_WAIT && !abort)
      |-> ph_ticks_reg == 5'h0a;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conv len");

  property p_acq_len;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == adcs_pkg::ST_ACQ && state_next == adcs_pkg::ST_CONV)
      |-> ph_ticks_reg + 5'h01 == acq_tads(acq_reg);
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acq len");

  property p_acq4;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == adcs_pkg::ST_ACQ && acq_reg == 3'b010 &&
       state_next == adcs_pkg::ST_CONV) |-> ph_ticks_reg == 5'h03;
  endproperty
  a_acq4: assert property (p_acq4) else $error("acq 4 wrong");

  property p_wait;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == adcs_pkg::ST_WAIT && state_next == adcs_pkg::ST_IDLE
       && on_reg) |-> ph_ticks_reg == 5'h01;
  endproperty
  a_wait: assert property (p_wait) else $error("wait len");

  property p_abort;
    @(posedge hclk) disable iff (!hresetn || !ce)
      (abort && !wr_resh && !wr_resl) |=>
        $stable(resh_reg) && $stable(resl_reg) &&
        state_reg != adcs_pkg::ST_CONV;
  endproperty
  a_abort: assert property (p_abort) else $error("abort changed");

  property p_finish;
    @(posedge hclk) disable iff (!hresetn || !ce)
      (finish && !wr_ctrl && !trig_go) |=>
        done_reg && !go_reg && {resh_reg, resl_reg} == $past(res_new);
  endproperty
  a_finish: assert property (p_finish) else $error("finish bad");

  property p_right;
    @(posedge hclk) disable iff (!hresetn || !ce)
      (finish && just_reg) |=>
        resh_reg[7:2] == 6'h00 &&
        {resh_reg[1:0], resl_reg} == $past(sar_data);
  endproperty
  a_right: assert property (p_right) else $error("justify bad");

  property p_trig_on;
    @(posedge hclk) disable iff (!hresetn || !ce)
      (trig && on_reg) |=> go_reg && timer_reset;
  endproperty
  a_trig_on: assert property (p_trig_on) else $error("trig on");

  property p_trig_off;
    @(posedge hclk) disable iff (!hresetn || !ce)
      (trig && !on_reg && !wr_ctrl) |=> !go_reg && timer_reset;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trig off");

  property p_port;
    @(posedge hclk) disable iff (!hresetn || !ce)
      (rd_pend && dp_addr_reg == adcs_pkg::OFF_PORT) |=>
        (hrdata_reg[NCH-1:0] & amask_w[NCH-1:0]) == '0;
  endproperty
  a_port: assert property (p_port) else $error("analog pin read");

  property p_fuse;
    @(posedge hclk) disable iff (!hresetn)
      $rose(init_reg) |-> pcfg_reg == ($past(portb_analog_at_reset) ?
        adcs_pkg::PCFG_RST : adcs_pkg::PCFG_PB_DIG);
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse reset bad");

endmodule // adcs_sequencer

/* sim/adcs_sar_model.sv */
module adcs_sar_model (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire adcs_pkg::adcs_ana_t ana,
  input  wire logic [9:0]          level,
  output logic      [9:0]          sar_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held_reg;

  // while sample_en is set the result lines toggle, so stale data shows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_reg <= 10'h000;
      sar_data <= 10'h3ff;
    end else if (ana.conv_start) begin
      held_reg <= level;
      sar_data <= level;
    end else if (ana.sample_en) begin
      sar_data <= ~sar_data;
    end else begin
      sar_data <= held_reg;
    end
  end
endmodule // adcs_sar_model

/* sim/adcs_sequencer_tb.sv */
module adcs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 0, hresetn = 0, rc_clk = 0, sleep_mode = 0;
  logic        hwrite = 0, special_event = 0, hreadyout, hresp;
  logic        conv_done, timer_reset, strap = 1;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, prev;
  logic [12:0] pin_in = 0;
  logic [9:0]  sar_data, level = 0;
  adcs_pkg::adcs_ana_t ana;
  int bad_count = 0, check_count = 0, cyc = 0, nstb = 0, gap, last = 0;
  int ntmr = 0, tst = 0, s0, t0;
  int acqt[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  always #25 hclk = ~hclk;
  always #97 rc_clk = ~rc_clk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    ntmr <= ntmr + int'(timer_reset);
    tst <= ana.conv_start ? cyc : tst;
    if (ana.bit_strobe) begin
      nstb <= nstb + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end

  adcs_sequencer i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rc_clk(rc_clk),
    .sleep_mode(sleep_mode), .special_event(special_event),
    .portb_analog_at_reset(strap), .pin_in(pin_in),
    .sar_data(sar_data), .ana(ana), .conv_done(conv_done),
    .timer_reset(timer_reset));
  adcs_sar_model i_sar (.hclk(hclk), .hresetn(hresetn), .ana(ana),
    .level(level), .sar_data(sar_data));

  task automatic final_report();
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic sig(input int k);
    return k == 0 ? hreadyout : k == 1 ? conv_done : ana.sample_en;
  endfunction

  // sampled at the falling edge: the value standing at the next rise
  task automatic until_hi(input int k, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (sig(k) !== 1'b1 && n < lim);
    if (n >= lim) begin
      bad_count++;
      final_report();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    until_hi(0, 50);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    until_hi(0, 50);
    rd = hrdata;
    @(posedge hclk);
  endtask

  function automatic logic [31:0] exp_res(logic [9:0] d, logic rj, logic hi);
    if (rj) return hi ? {30'h0, d[9:8]} : {24'h0, d[7:0]};
    return hi ? {24'h0, d[9:2]} : {24'h0, d[1:0], 6'h0};
  endfunction

  task automatic conv(input logic [2:0] cs, input logic [2:0] acq,
                      input logic rj);
    int p, lo;
    p = 2 << {cs[1:0], cs[2]};
    lo = acqt[acq] * p + (acq == 3'h0 ? 4 : 0);
    s0 = nstb;
    @(posedge hclk);
    level <= 10'($urandom);
    sleep_mode <= &cs[1:0]; // rc clock whenever asleep
    ahb(1'b1, adcs_pkg::OFF_TIMING, {24'h0, rj, 1'b0, acq, cs});
    ahb(1'b1, adcs_pkg::OFF_CTRL, 32'h5); // on before go
    ahb(1'b1, adcs_pkg::OFF_CTRL, 32'h7);
    t0 = cyc;
    until_hi(1, 6000);
    s0 = nstb - s0;
    lo = tst - t0 - lo;
    t0 = cyc;
    until_hi(2, 400);
    chk(32'(s0), 32'd11);
    chk({28'h0, ana.channel}, 32'h1);
    if (!(&cs[1:0])) begin
      chk(32'(gap), 32'(p));
      chk(32'(lo >= -1 && lo <= 3), 32'h1);
      chk(32'(cyc - t0 >= 2 * p - 1 && cyc - t0 <= 2 * p + 3), 32'h1);
    end
    ahb(1'b0, adcs_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h5);
    ahb(1'b0, adcs_pkg::OFF_RESH, 32'h0);
    chk(rd, exp_res(level, rj, 1'b1));
    ahb(1'b0, adcs_pkg::OFF_RESL, 32'h0);
    chk(rd, exp_res(level, rj, 1'b0));
    ahb(1'b1, adcs_pkg::OFF_STAT, 32'h1);
    ahb(1'b0, adcs_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic pulse();
    @(posedge hclk);
    special_event <= 1'b1;
    @(posedge hclk);
    special_event <= 1'b0;
    repeat (2) @(negedge hclk);
  endtask

  initial begin
    void'($urandom(32'h840f));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, adcs_pkg::OFF_PINCFG, 32'h0);
    chk(rd, {28'h0, adcs_pkg::PCFG_RST});
    ahb(1'b0, adcs_pkg::OFF_NONE, 32'h0);
    chk(rd, 32'h0);
    pin_in <= 13'($urandom);
    ahb(1'b1, adcs_pkg::OFF_PINCFG, 32'hf);
    ahb(1'b0, adcs_pkg::OFF_PORT, 32'h0);
    chk(rd, {19'h0, pin_in});
    ahb(1'b1, adcs_pkg::OFF_PINCFG, 32'h0);
    ahb(1'b0, adcs_pkg::OFF_PORT, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) conv(3'(i), 3'(i + 2), 1'(i));
    // after the corners, only the slow divider or rc, as software should
    repeat (3) begin
      conv(3'($urandom) | 3'h6, 3'($urandom), 1'($urandom));
    end
    // abort well inside a slow conversion
    ahb(1'b1, adcs_pkg::OFF_TIMING, 32'h6);
    sleep_mode <= 1'b0;
    ahb(1'b0, adcs_pkg::OFF_RESL, 32'h0);
    prev = rd;
    ahb(1'b1, adcs_pkg::OFF_CTRL, 32'h7);
    repeat (300) @(posedge hclk);
    ahb(1'b1, adcs_pkg::OFF_CTRL, 32'h5);
    t0 = cyc;
    until_hi(2, 400);
    chk(32'(cyc - t0 >= 127 && cyc - t0 <= 131), 32'h1);
    chk({31'h0, conv_done}, 32'h0);
    ahb(1'b0, adcs_pkg::OFF_RESL, 32'h0);
    chk(rd, prev);
    s0 = ntmr;
    pulse();
    chk(32'(ntmr - s0), 32'h0);
    ahb(1'b1, adcs_pkg::OFF_CMP, {28'h0, adcs_pkg::CMP_TRIG_MODE});
    ahb(1'b1, adcs_pkg::OFF_CTRL, 32'h0);
    s0 = ntmr;
    pulse();
    chk(32'(ntmr - s0), 32'h1);
    ahb(1'b0, adcs_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, adcs_pkg::OFF_CTRL, 32'h5); // channel set first
    t0 = nstb;
    pulse();
    chk(32'(ntmr - s0), 32'h2);
    until_hi(1, 6000);
    chk(32'(nstb - t0), 32'd11);
    // second reset, strap now digital
    @(posedge hclk);
    strap <= 1'b0;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, adcs_pkg::OFF_PINCFG, 32'h0);
    chk(rd, {28'h0, adcs_pkg::PCFG_PB_DIG});
    final_report();
  end
endmodule // adcs_sequencer_tb
